// ==== design/bcs_top.sv ====
// Boot cluster swap remapper with debug option loading and pin override.
// Assumes a flash array that returns read data one cycle after the
// registered address, and a nonvolatile swap flag that is stable at reset.
`timescale 1ns/100ps
`default_nettype none

module bcs_top #(
  parameter int unsigned ROM_KB = 8
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        nv_swap_i,
  input  wire logic        swap_req_i,
  output logic             nv_wr_o,
  output logic             nv_wr_data_o,
  input  wire logic        cpu_req_i,
  input  wire logic [15:0] cpu_addr_i,
  output logic             flash_req_o,
  output logic [15:0]      flash_addr_o,
  input  wire logic [7:0]  flash_rdata_i,
  output logic             boot_ready_o,
  output logic             swap_active_o,
  input  wire logic        id_start_i,
  input  wire logic        id_valid_i,
  input  wire logic [7:0]  id_byte_i,
  output logic             id_ok_o,
  output logic             dbg_permit_o,
  input  wire logic        dbg_connect_i,
  input  wire logic        pair_sel_i,
  input  wire logic        flash_prog_i,
  input  wire logic [2:0]  clk_req_i,
  input  wire logic        stop_i,
  output logic [2:0]       clk_sel_o,
  output logic             hoco_keep_o,
  input  wire logic        debug_clock_pin_primary_i,
  output logic             debug_clock_pin_primary_o,
  output logic             debug_clock_pin_primary_oe_o,
  input  wire logic        debug_data_pin_primary_i,
  output logic             debug_data_pin_primary_o,
  output logic             debug_data_pin_primary_oe_o,
  input  wire logic        debug_clock_pin_alternate_i,
  output logic             debug_clock_pin_alternate_o,
  output logic             debug_clock_pin_alternate_oe_o,
  input  wire logic        debug_data_pin_alternate_i,
  output logic             debug_data_pin_alternate_o,
  output logic             debug_data_pin_alternate_oe_o,
  input  wire logic [3:0]  user_out_i,
  input  wire logic [3:0]  user_oe_i,
  output logic [3:0]       user_in_o,
  input  wire logic        link_tx_i,
  input  wire logic        link_tx_oe_i,
  output logic             link_clk_o,
  output logic             link_rx_o,
  output logic             dbg_active_o
);

  // Swap is only offered on parts larger than one cluster.
  localparam bit SWAP_OK = (ROM_KB > bcs_pkg::ROM_KB_NO_SWAP);

  // Maps a logical address onto flash; inside the two low clusters the
  // cluster bit flips when swapped, so the debug bytes move too.
  function automatic logic [15:0] remap(input logic [15:0] a,
                                        input logic        sw);
    logic [15:0] r;
    r = a;
    if (sw && (a < bcs_pkg::BOOT_AREA_END)) begin
      r[bcs_pkg::CLUSTER_BIT] = ~a[bcs_pkg::CLUSTER_BIT];
    end
    return r;
  endfunction

  // Loader and swap state.
  bcs_pkg::bcs_state_t st_reg, st_next;
  logic        swap_reg, swap_next;
  logic        pend_reg, pend_next;
  logic        nvwr_reg, nvwr_next;
  logic [3:0]  ld_reg, ld_next;
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [7:0]  id_mem [bcs_pkg::OCD_ID_LEN];
  logic [15:0] faddr_reg, faddr_next;
  logic        freq_reg, freq_next;
  logic        rdy_reg, rdy_next;

  // Identifier check state.
  logic [3:0]  idx_reg, idx_next;
  logic        match_reg, match_next;
  logic        ok_reg, ok_next;
  logic        permit_reg, permit_next;

  // Pin synchronisers: four pins plus the connect detect.
  logic [4:0]  s1_reg, s2_reg, s3_reg, filt_reg, filt_next;

  // Pin mux and clock outputs.
  logic [3:0]  pout_reg, pout_next, poe_reg, poe_next, uin_reg, uin_next;
  logic        lclk_reg, lclk_next, lrx_reg, lrx_next;
  logic        act_reg, act_next;
  logic [2:0]  csel_reg, csel_next;
  logic        keep_reg, keep_next;

  // Next values for swap capture, commit requests and the option loader.
  always_comb begin
    st_next    = st_reg;
    swap_next  = swap_reg;
    pend_next  = pend_reg;
    nvwr_next  = 1'b0;
    ld_next    = ld_reg;
    ctrl_next  = ctrl_reg;
    faddr_next = faddr_reg;
    freq_next  = 1'b0;
    rdy_next   = rdy_reg;
    case (st_reg)
      bcs_pkg::ST_BOOT: begin
        // The stored flag is caught once after reset; later writes wait.
        swap_next = nv_swap_i & SWAP_OK;
        pend_next = nv_swap_i & SWAP_OK;
        ld_next   = 4'h0;
        st_next   = bcs_pkg::ST_ISSUE;
      end
      bcs_pkg::ST_ISSUE: begin
        faddr_next = remap(bcs_pkg::OCD_CTRL_ADDR + {12'h000, ld_reg},
                           swap_reg);
        freq_next  = 1'b1;
        st_next    = bcs_pkg::ST_WAIT;
      end
      bcs_pkg::ST_WAIT: begin
        st_next = bcs_pkg::ST_TAKE;
      end
      bcs_pkg::ST_TAKE: begin
        if (ld_reg == 4'h0) begin
          ctrl_next = flash_rdata_i;
        end
        if (ld_reg == bcs_pkg::LD_IDX_LAST) begin
          rdy_next = 1'b1;
          st_next  = bcs_pkg::ST_RUN;
        end else begin
          ld_next = ld_reg + 4'h1;
          st_next = bcs_pkg::ST_ISSUE;
        end
      end
      bcs_pkg::ST_RUN: begin
        faddr_next = remap(cpu_addr_i, swap_reg);
        freq_next  = cpu_req_i;
      end
      default: begin
        st_next = bcs_pkg::ST_BOOT;
      end
    endcase
    // A request flips the stored flag; the live mapping is untouched.
    if (swap_req_i && SWAP_OK) begin
      pend_next = ~pend_next;
      nvwr_next = 1'b1;
    end
  end

  // Registers for the loader and swap state.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg    <= bcs_pkg::ST_BOOT;
      swap_reg  <= 1'b0;
      pend_reg  <= 1'b0;
      nvwr_reg  <= 1'b0;
      ld_reg    <= 4'h0;
      ctrl_reg  <= 8'h00;
      faddr_reg <= 16'h0000;
      freq_reg  <= 1'b0;
      rdy_reg   <= 1'b0;
    end else begin
      st_reg    <= st_next;
      swap_reg  <= swap_next;
      pend_reg  <= pend_next;
      nvwr_reg  <= nvwr_next;
      ld_reg    <= ld_next;
      ctrl_reg  <= ctrl_next;
      faddr_reg <= faddr_next;
      freq_reg  <= freq_next;
      rdy_reg   <= rdy_next;
    end
  end

  // Identifier bytes are kept as read; the array needs no reset.
  always_ff @(posedge sys_clk_i) begin
    if (st_reg == bcs_pkg::ST_TAKE && ld_reg != 4'h0) begin
      id_mem[ld_reg - 4'h1] <= flash_rdata_i;
    end
  end

  // Next values for the identifier comparison and debug permission.
  always_comb begin
    idx_next    = idx_reg;
    match_next  = match_reg;
    ok_next     = ok_reg;
    if (id_start_i) begin
      idx_next   = 4'h0;
      match_next = 1'b1;
      ok_next    = 1'b0;
    end else if (id_valid_i && rdy_reg &&
                 idx_reg <= bcs_pkg::ID_IDX_LAST) begin
      match_next = match_reg & (id_byte_i == id_mem[idx_reg]);
      idx_next   = idx_reg + 4'h1;
      if (idx_reg == bcs_pkg::ID_IDX_LAST) begin
        ok_next = match_next;
      end
    end
    permit_next = rdy_reg & ctrl_reg[bcs_pkg::OCD_EN_BIT] & ok_next;
  end

  // Registers for the identifier check.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idx_reg    <= 4'h0;
      match_reg  <= 1'b0;
      ok_reg     <= 1'b0;
      permit_reg <= 1'b0;
    end else begin
      idx_reg    <= idx_next;
      match_reg  <= match_next;
      ok_reg     <= ok_next;
      permit_reg <= permit_next;
    end
  end

  // A level counts once the second and third stages agree.
  always_comb begin
    filt_next = filt_reg;
    for (int i = 0; i <= bcs_pkg::PIN_N; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        filt_next[i] = s3_reg[i];
      end
    end
  end

  // Three-stage synchronisers for the pins and the connect detect.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_reg   <= 5'h00;
      s2_reg   <= 5'h00;
      s3_reg   <= 5'h00;
      filt_reg <= 5'h00;
    end else begin
      s1_reg   <= {dbg_connect_i, debug_data_pin_alternate_i,
                   debug_clock_pin_alternate_i, debug_data_pin_primary_i,
                   debug_clock_pin_primary_i};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  // Pin ownership, link signals and clock selection.
  always_comb begin
    logic dc;
    logic dd;
    dc = pair_sel_i ? filt_reg[bcs_pkg::PIN_CLK_ALT]
                    : filt_reg[bcs_pkg::PIN_CLK_PRI];
    dd = pair_sel_i ? filt_reg[bcs_pkg::PIN_DAT_ALT]
                    : filt_reg[bcs_pkg::PIN_DAT_PRI];
    act_next  = filt_reg[bcs_pkg::PIN_N] & permit_reg;
    pout_next = user_out_i;
    poe_next  = user_oe_i;
    uin_next  = filt_reg[3:0];
    lclk_next = 1'b0;
    lrx_next  = 1'b0;
    if (act_next) begin
      // The chosen pair belongs to the link; user settings are dropped.
      if (pair_sel_i) begin
        pout_next[bcs_pkg::PIN_CLK_ALT] = 1'b0;
        poe_next[bcs_pkg::PIN_CLK_ALT]  = 1'b0;
        pout_next[bcs_pkg::PIN_DAT_ALT] = link_tx_i;
        poe_next[bcs_pkg::PIN_DAT_ALT]  = link_tx_oe_i;
        uin_next[bcs_pkg::PIN_CLK_ALT]  = 1'b0;
        uin_next[bcs_pkg::PIN_DAT_ALT]  = 1'b0;
      end else begin
        pout_next[bcs_pkg::PIN_CLK_PRI] = 1'b0;
        poe_next[bcs_pkg::PIN_CLK_PRI]  = 1'b0;
        pout_next[bcs_pkg::PIN_DAT_PRI] = link_tx_i;
        poe_next[bcs_pkg::PIN_DAT_PRI]  = link_tx_oe_i;
        uin_next[bcs_pkg::PIN_CLK_PRI]  = 1'b0;
        uin_next[bcs_pkg::PIN_DAT_PRI]  = 1'b0;
      end
      lclk_next = dc;
      lrx_next  = dd;
    end
    // Only the listed sources are legal; anything else falls back.
    case (clk_req_i)
      bcs_pkg::CLK_BOARD,
      bcs_pkg::CLK_EMU_4M,
      bcs_pkg::CLK_EMU_8M,
      bcs_pkg::CLK_EMU_16M: csel_next = clk_req_i;
      default: csel_next = bcs_pkg::CLK_HOCO;
    endcase
    if (flash_prog_i) begin
      csel_next = bcs_pkg::CLK_HOCO;
    end
    keep_next = act_next & stop_i;
  end

  // Registers for the pin mux and clock controls.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pout_reg <= 4'h0;
      poe_reg  <= 4'h0;
      uin_reg  <= 4'h0;
      lclk_reg <= 1'b0;
      lrx_reg  <= 1'b0;
      act_reg  <= 1'b0;
      csel_reg <= bcs_pkg::CLK_HOCO;
      keep_reg <= 1'b0;
    end else begin
      pout_reg <= pout_next;
      poe_reg  <= poe_next;
      uin_reg  <= uin_next;
      lclk_reg <= lclk_next;
      lrx_reg  <= lrx_next;
      act_reg  <= act_next;
      csel_reg <= csel_next;
      keep_reg <= keep_next;
    end
  end

  // Outputs come straight from the registers above.
  assign nv_wr_o                        = nvwr_reg;
  assign nv_wr_data_o                   = pend_reg;
  assign flash_req_o                    = freq_reg;
  assign flash_addr_o                   = faddr_reg;
  assign boot_ready_o                   = rdy_reg;
  assign swap_active_o                  = swap_reg;
  assign id_ok_o                        = ok_reg;
  assign dbg_permit_o                   = permit_reg;
  assign clk_sel_o                      = csel_reg;
  assign hoco_keep_o                    = keep_reg;
  assign debug_clock_pin_primary_o      = pout_reg[bcs_pkg::PIN_CLK_PRI];
  assign debug_clock_pin_primary_oe_o   = poe_reg[bcs_pkg::PIN_CLK_PRI];
  assign debug_data_pin_primary_o       = pout_reg[bcs_pkg::PIN_DAT_PRI];
  assign debug_data_pin_primary_oe_o    = poe_reg[bcs_pkg::PIN_DAT_PRI];
  assign debug_clock_pin_alternate_o    = pout_reg[bcs_pkg::PIN_CLK_ALT];
  assign debug_clock_pin_alternate_oe_o = poe_reg[bcs_pkg::PIN_CLK_ALT];
  assign debug_data_pin_alternate_o     = pout_reg[bcs_pkg::PIN_DAT_ALT];
  assign debug_data_pin_alternate_oe_o  = poe_reg[bcs_pkg::PIN_DAT_ALT];
  assign user_in_o                      = uin_reg;
  assign link_clk_o                     = lclk_reg;
  assign link_rx_o                      = lrx_reg;
  assign dbg_active_o                   = act_reg;

endmodule

`default_nettype wire

// ==== design/bcs_pkg.sv ====
// Constants and types for the boot cluster swap and debug access block.
// Assumes a 16-bit flash byte address space with the boot area at zero.
package bcs_pkg;

  // Boot cluster geometry: each cluster spans 4 KB.
  localparam int unsigned BOOT_CLUSTER_BYTES = 4096;
  localparam int unsigned ADDR_W             = 16;
  localparam int unsigned CLUSTER_BIT        = 12;
  localparam logic [15:0] BOOT_AREA_END      = 16'h2000;

  // Program memory size at or below which no swap is offered.
  localparam int unsigned ROM_KB_NO_SWAP = 4;

  // Debug control byte and security identifier locations.
  localparam logic [15:0] OCD_CTRL_ADDR = 16'h0084;
  localparam logic [15:0] OCD_ID_FIRST  = 16'h0085;
  localparam logic [15:0] OCD_ID_LAST   = 16'h008E;
  localparam int unsigned OCD_ID_LEN    = 10;
  localparam int unsigned OCD_EN_BIT    = 0;
  localparam logic [3:0]  LD_IDX_LAST   = 4'hA;
  localparam logic [3:0]  ID_IDX_LAST   = 4'h9;

  // Operating clock choices.
  localparam int unsigned CLK_SRC_W  = 3;
  localparam logic [2:0]  CLK_HOCO   = 3'h0;
  localparam logic [2:0]  CLK_BOARD  = 3'h1;
  localparam logic [2:0]  CLK_EMU_4M = 3'h2;
  localparam logic [2:0]  CLK_EMU_8M = 3'h3;
  localparam logic [2:0]  CLK_EMU_16M = 3'h4;

  // Debug pin indices in the pin vectors.
  localparam int unsigned PIN_CLK_PRI = 0;
  localparam int unsigned PIN_DAT_PRI = 1;
  localparam int unsigned PIN_CLK_ALT = 2;
  localparam int unsigned PIN_DAT_ALT = 3;
  localparam int unsigned PIN_N       = 4;

  // Loader states.
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_ISSUE,
    ST_WAIT,
    ST_TAKE,
    ST_RUN
  } bcs_state_t;

endpackage

// ==== sim/bcs_chk_sva.sv ====
// Checker for the boot cluster swap block, watching top-level ports only.
// Assumes a single clock domain and the active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none

module bcs_chk #(
  parameter int unsigned ROM_KB = 8
) (
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic        swap_req_i,
  input wire logic        nv_wr_o,
  input wire logic        nv_wr_data_o,
  input wire logic        cpu_req_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic        flash_req_o,
  input wire logic [15:0] flash_addr_o,
  input wire logic        boot_ready_o,
  input wire logic        swap_active_o,
  input wire logic        id_start_i,
  input wire logic        id_ok_o,
  input wire logic        dbg_permit_o,
  input wire logic        flash_prog_i,
  input wire logic [2:0]  clk_req_i,
  input wire logic        stop_i,
  input wire logic [2:0]  clk_sel_o,
  input wire logic        hoco_keep_o,
  input wire logic        dbg_active_o
);

  // All checks share the system clock and drop out during reset.
  default clocking dc @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_remap;
    boot_ready_o && cpu_req_i |=> flash_req_o && flash_addr_o ==
      ($past(cpu_addr_i) ^ ((swap_active_o && $past(cpu_addr_i) < 16'h2000)
      ? 16'h1000 : 16'h0000));
  endproperty
  a_remap: assert property (p_remap) else $error("bad map");

  // Option bytes are fetched from the cluster that the live mapping names.
  property p_load;
    flash_req_o && !boot_ready_o |->
      flash_addr_o[15:4] == {3'h0, swap_active_o, 8'h08};
  endproperty
  a_load: assert property (p_load) else $error("option map");

  property p_wr_cause;
    nv_wr_o |-> $past(swap_req_i) && ROM_KB > 4;
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("stray write");

  property p_wr;
    ROM_KB > 4 && swap_req_i |=>
      nv_wr_o && nv_wr_data_o != $past(nv_wr_data_o);
  endproperty
  a_wr: assert property (p_wr) else $error("swap not stored");

  property p_swap_hold;
    boot_ready_o |=> $stable(swap_active_o);
  endproperty
  a_swap_hold: assert property (p_swap_hold) else $error("map moved");

  property p_id_clr;
    id_start_i |=> !id_ok_o && !dbg_permit_o;
  endproperty
  a_id_clr: assert property (p_id_clr) else $error("id flag kept");

  property p_permit;
    dbg_permit_o |-> id_ok_o;
  endproperty
  a_permit: assert property (p_permit) else $error("permit w/o id");

  property p_prog;
    flash_prog_i |=> clk_sel_o == bcs_pkg::CLK_HOCO;
  endproperty
  a_prog: assert property (p_prog) else $error("prog clock wrong");

  property p_clk;
    !flash_prog_i |=> clk_sel_o == (($past(clk_req_i) <= bcs_pkg::CLK_EMU_16M)
      ? $past(clk_req_i) : bcs_pkg::CLK_HOCO);
  endproperty
  a_clk: assert property (p_clk) else $error("debug clock wrong");

  property p_hoco;
    dbg_active_o && stop_i |=> hoco_keep_o || !dbg_active_o;
  endproperty
  a_hoco: assert property (p_hoco) else $error("osc not kept");

endmodule

bind bcs_top bcs_chk #(
  .ROM_KB (ROM_KB)
) bcs_chk_inst (
  .sys_clk_i     (sys_clk_i),
  .rstn_i        (rstn_i),
  .swap_req_i    (swap_req_i),
  .nv_wr_o       (nv_wr_o),
  .nv_wr_data_o  (nv_wr_data_o),
  .cpu_req_i     (cpu_req_i),
  .cpu_addr_i    (cpu_addr_i),
  .flash_req_o   (flash_req_o),
  .flash_addr_o  (flash_addr_o),
  .boot_ready_o  (boot_ready_o),
  .swap_active_o (swap_active_o),
  .id_start_i    (id_start_i),
  .id_ok_o       (id_ok_o),
  .dbg_permit_o  (dbg_permit_o),
  .flash_prog_i  (flash_prog_i),
  .clk_req_i     (clk_req_i),
  .stop_i        (stop_i),
  .clk_sel_o     (clk_sel_o),
  .hoco_keep_o   (hoco_keep_o),
  .dbg_active_o  (dbg_active_o)
);

`default_nettype wire

// ==== sim/bcs_flash_model.sv ====
// Flash array model facing the block's flash port.
// Assumes data is wanted one cycle after the registered request.
`timescale 1ns/100ps
`default_nettype none

module bcs_flash_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [15:0] addr_i,
  output logic [7:0]       rdata_o
);

  // Option bytes read alike in both clusters; idle data keeps changing.
  always_ff @(posedge clk_i) begin
    if (req_i) begin
      rdata_o <= (addr_i[11:4] == 8'h08) ? (addr_i[7:0] | 8'h01)
                                         : ~addr_i[7:0];
    end else begin
      rdata_o <= ~rdata_o;
    end
  end

endmodule

`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the boot cluster swap block.
// Assumes the flash model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("FAIL t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end

module tb_top;
  logic        sys_clk_i = 1'b0, rstn_i = 1'b0, nv_swap_i = 1'b0;
  logic        swap_req_i = 1'b0, cpu_req_i = 1'b0, id_start_i = 1'b0;
  logic        id_valid_i = 1'b0, dbg_connect_i = 1'b0, pair_sel_i = 1'b0;
  logic        flash_prog_i = 1'b0, stop_i = 1'b0, link_tx_i = 1'b0;
  logic        link_tx_oe_i = 1'b0, pin_lvl = 1'b0;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic [7:0]  id_byte_i = 8'h00;
  logic [2:0]  clk_req_i = 3'h0;
  logic [3:0]  user_out_i = 4'hF, user_oe_i = 4'hF;
  logic        debug_clock_pin_alternate_i = 1'b0;
  logic        debug_data_pin_alternate_i = 1'b0;
  logic        debug_clock_pin_primary_i, debug_data_pin_primary_i;
  logic        nv_wr_o, nv_wr_data_o, flash_req_o, boot_ready_o;
  logic        swap_active_o, id_ok_o, dbg_permit_o, hoco_keep_o;
  logic        link_clk_o, link_rx_o, dbg_active_o;
  logic        debug_clock_pin_primary_o, debug_clock_pin_primary_oe_o;
  logic        debug_data_pin_primary_o, debug_data_pin_primary_oe_o;
  logic        debug_clock_pin_alternate_o, debug_clock_pin_alternate_oe_o;
  logic        debug_data_pin_alternate_o, debug_data_pin_alternate_oe_o;
  logic [15:0] flash_addr_o;
  logic [7:0]  flash_rdata_i;
  logic [2:0]  clk_sel_o;
  logic [3:0]  user_in_o;
  int          n_errors = 0, checks_done = 0, cyc = 0;

  // The emulator drives both primary pins to one level.
  assign debug_clock_pin_primary_i = pin_lvl;
  assign debug_data_pin_primary_i  = pin_lvl;

  bcs_top #(
    .ROM_KB (8)
  ) bcs_top_inst (
    .sys_clk_i                      (sys_clk_i),
    .rstn_i                         (rstn_i),
    .nv_swap_i                      (nv_swap_i),
    .swap_req_i                     (swap_req_i),
    .nv_wr_o                        (nv_wr_o),
    .nv_wr_data_o                   (nv_wr_data_o),
    .cpu_req_i                      (cpu_req_i),
    .cpu_addr_i                     (cpu_addr_i),
    .flash_req_o                    (flash_req_o),
    .flash_addr_o                   (flash_addr_o),
    .flash_rdata_i                  (flash_rdata_i),
    .boot_ready_o                   (boot_ready_o),
    .swap_active_o                  (swap_active_o),
    .id_start_i                     (id_start_i),
    .id_valid_i                     (id_valid_i),
    .id_byte_i                      (id_byte_i),
    .id_ok_o                        (id_ok_o),
    .dbg_permit_o                   (dbg_permit_o),
    .dbg_connect_i                  (dbg_connect_i),
    .pair_sel_i                     (pair_sel_i),
    .flash_prog_i                   (flash_prog_i),
    .clk_req_i                      (clk_req_i),
    .stop_i                         (stop_i),
    .clk_sel_o                      (clk_sel_o),
    .hoco_keep_o                    (hoco_keep_o),
    .debug_clock_pin_primary_i      (debug_clock_pin_primary_i),
    .debug_clock_pin_primary_o      (debug_clock_pin_primary_o),
    .debug_clock_pin_primary_oe_o   (debug_clock_pin_primary_oe_o),
    .debug_data_pin_primary_i       (debug_data_pin_primary_i),
    .debug_data_pin_primary_o       (debug_data_pin_primary_o),
    .debug_data_pin_primary_oe_o    (debug_data_pin_primary_oe_o),
    .debug_clock_pin_alternate_i    (debug_clock_pin_alternate_i),
    .debug_clock_pin_alternate_o    (debug_clock_pin_alternate_o),
    .debug_clock_pin_alternate_oe_o (debug_clock_pin_alternate_oe_o),
    .debug_data_pin_alternate_i     (debug_data_pin_alternate_i),
    .debug_data_pin_alternate_o     (debug_data_pin_alternate_o),
    .debug_data_pin_alternate_oe_o  (debug_data_pin_alternate_oe_o),
    .user_out_i                     (user_out_i),
    .user_oe_i                      (user_oe_i),
    .user_in_o                      (user_in_o),
    .link_tx_i                      (link_tx_i),
    .link_tx_oe_i                   (link_tx_oe_i),
    .link_clk_o                     (link_clk_o),
    .link_rx_o                      (link_rx_o),
    .dbg_active_o                   (dbg_active_o)
  );

  bcs_flash_model bcs_flash_model_inst (
    .clk_i   (sys_clk_i),
    .req_i   (flash_req_o),
    .addr_i  (flash_addr_o),
    .rdata_o (flash_rdata_i)
  );

  // Free-running 100 MHz clock.
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Cycle ceiling that cuts a hang short.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // Resets for 20 cycles with a given stored swap flag, then awaits boot.
  task automatic do_reset(input logic nv);
    rstn_i = 1'b0;
    nv_swap_i = nv;
    step(20);
    `CHK(boot_ready_o, 1'b0)
    rstn_i = 1'b1;
    for (int k = 0; k < 100 && boot_ready_o !== 1'b1; k++) begin
      step(1);
    end
    `CHK(boot_ready_o, 1'b1)
    `CHK(swap_active_o, nv)
    $display("reset done, swap flag %0h", nv);
  endtask

  // Back-to-back fetches inside, at the edge of and beyond the boot area.
  task automatic t_remap(input logic sw);
    logic [15:0] a [3] = '{16'h0084, 16'h1FFF, 16'h2000};
    logic [15:0] e;
    for (int i = 0; i < 3; i++) begin
      cpu_req_i = 1'b1;
      cpu_addr_i = a[i];
      e = (sw && a[i] < 16'h2000) ? (a[i] ^ 16'h1000) : a[i];
      step(1);
      `CHK(flash_req_o, 1'b1)
      `CHK(flash_addr_o, e)
    end
    cpu_req_i = 1'b0;
    step(1);
    `CHK(flash_req_o, 1'b0)
    $display("remap test done");
  endtask

  // Two back-to-back swap requests toggle the stored flag twice.
  task automatic t_swap();
    swap_req_i = 1'b1; // new boot program already sits in cluster 1
    step(1);
    `CHK(nv_wr_o, 1'b1)
    `CHK(nv_wr_data_o, 1'b1)
    step(1);
    swap_req_i = 1'b0;
    `CHK(nv_wr_o, 1'b1)
    `CHK(nv_wr_data_o, 1'b0)
    step(1);
    `CHK(nv_wr_o, 1'b0)
    `CHK(swap_active_o, 1'b0)
    $display("swap test done");
  endtask

  // Enters the 10 identifier bytes, spoiling one when bad is below 10.
  task automatic t_id(input int bad);
    logic [7:0] b;
    id_start_i = 1'b1;
    step(1);
    id_start_i = 1'b0;
    id_valid_i = 1'b1;
    for (int k = 0; k < 10; k++) begin
      b = (8'h85 + 8'(k)) | 8'h01;
      id_byte_i = (k == bad) ? ~b : b;
      step(1);
    end
    id_valid_i = 1'b0;
    step(2);
    `CHK(id_ok_o, bad > 9)
    `CHK(dbg_permit_o, bad > 9)
    $display("id test done, spoiled byte %0d", bad);
  endtask

  // Debug link on both pin pairs, stop mode and every clock code.
  task automatic t_debug();
    dbg_connect_i = 1'b1;
    link_tx_oe_i = 1'b1;
    pin_lvl = 1'b1;
    step(10);
    `CHK(dbg_active_o, 1'b1)
    `CHK(debug_clock_pin_primary_oe_o, 1'b0)
    `CHK(debug_data_pin_primary_oe_o, 1'b1)
    `CHK(link_clk_o, 1'b1)
    `CHK(link_rx_o, 1'b1)
    `CHK(user_in_o[1:0], 2'h0)
    `CHK(debug_clock_pin_primary_o, 1'b0)
    `CHK(debug_data_pin_primary_o, link_tx_i)
    pair_sel_i = 1'b1;
    link_tx_oe_i = 1'b0;
    step(3);
    `CHK(debug_data_pin_alternate_oe_o, 1'b0)
    link_tx_oe_i = 1'b1;
    step(4);
    `CHK(debug_data_pin_alternate_oe_o, 1'b1)
    `CHK(debug_clock_pin_alternate_oe_o, 1'b0)
    `CHK(link_clk_o, 1'b0)
    `CHK(debug_clock_pin_primary_oe_o, 1'b1)
    `CHK(debug_data_pin_alternate_o, 1'b0)
    `CHK(user_in_o, 4'h3)
    stop_i = 1'b1;
    step(2);
    `CHK(hoco_keep_o, 1'b1)
    stop_i = 1'b0;
    step(2);
    `CHK(hoco_keep_o, 1'b0)
    for (int c = 0; c < 8; c++) begin
      clk_req_i = 3'(c);
      flash_prog_i = 1'b0;
      step(2);
      `CHK(clk_sel_o, (c <= 4) ? 3'(c) : bcs_pkg::CLK_HOCO)
      flash_prog_i = 1'b1;
      step(2);
      `CHK(clk_sel_o, bcs_pkg::CLK_HOCO)
    end
    flash_prog_i = 1'b0;
    dbg_connect_i = 1'b0;
    step(8);
    `CHK(dbg_active_o, 1'b0)
    `CHK(debug_data_pin_alternate_o, 1'b1)
    `CHK(debug_clock_pin_alternate_oe_o, 1'b1)
    $display("debug test done");
  endtask

  // Main sequence, with a second reset that commits the swap.
  initial begin
    do_reset(1'b0);
    t_swap();
    t_remap(1'b0);
    t_id(9);
    t_id(0);
    t_id(10);
    t_debug();
    do_reset(1'b1);
    t_remap(1'b1);
    t_id(10);
    give_verdict();
  end

endmodule

`default_nettype wire
